// >>> logic/decim_pkg.sv
// Shared constants for the final decimation stage and its tap weight store
package decim_pkg;
    // ------------------------------------------------------------
    // Data path sizes
    // ------------------------------------------------------------
    localparam int TAPS = 128;
    localparam int TAP_IDX_W = 7;
    localparam int COEF_W = 32;
    localparam int SAMPLE_W = 24;
    localparam int ACC_W = 64;
    localparam int ROUND_POS = 31;
    localparam logic [ACC_W-1:0] ROUND_ADD = 64'h0000_0000_4000_0000;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_PTR_W = 4;

    // ------------------------------------------------------------
    // Tap weight store and register map
    // ------------------------------------------------------------
    localparam int BANK_BYTES = 512;
    localparam int BANK_PTR_W = 9;
    localparam logic [BANK_PTR_W-1:0] BANK_PTR_FIRST = 9'h000;
    localparam logic [BANK_PTR_W-1:0] BANK_PTR_LAST = 9'h1FF;
    localparam logic [7:0] TAP_WEIGHT_WINDOW_ADDR = 8'h13;
    localparam logic [TAP_IDX_W-1:0] TOP_TAP = 7'h7F;

    // ------------------------------------------------------------
    // Coefficient source and built-in weights
    // ------------------------------------------------------------
    localparam logic [2:0] SRC_BUILTIN = 3'h0;
    localparam logic [2:0] SRC_USER = 3'h7;
    // 1/128 in 1.31: symmetric, unity gain, linear phase
    localparam logic [COEF_W-1:0] BUILTIN_COEF = 32'h0100_0000;
    localparam logic [COEF_W-1:0] COEF_MIN = 32'h8000_0000;
    localparam logic [COEF_W-1:0] COEF_MAX = 32'h7FFF_FFFF;

    // ------------------------------------------------------------
    // Settling and timing
    // ------------------------------------------------------------
    localparam logic [6:0] SETTLE_BUILTIN = 7'h44;
    localparam logic [6:0] SETTLE_USER = 7'h4B;
    localparam int UNSETTLED_NO_SYNC = 69;
    localparam int GROUP_DELAY_PERIODS = 34;
    localparam logic [4:0] OVERHEAD_CLKS = 5'h10;
    localparam int CLK_PERIOD_NS = 50;
    localparam int MIN_FRAME_GAP_CLKS = 10;
    localparam int MIN_FRAME_GAP_NS = MIN_FRAME_GAP_CLKS * CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_MAC,
        ST_ROUND,
        ST_HOLD,
        ST_PUSH
    } fir_state_t;
endpackage

// >>> logic/final_decimator_coef_bank.sv
// Final 128-tap decimate-by-two FIR stage with its byte-wide tap weight store
//
// Contract
// (RQ1) Final stage is a 128-tap FIR decimating by exactly two.
// (RQ2) Tap weights are signed 32-bit 1.31 values from -1 to just below +1.
// (RQ3) A bypass skips both the filtering and the divide-by-two.
// (RQ4) First output after restart: 75 periods (user) or 68 (built-in) plus 16 clocks.
// (RQ5) Source field 000b picks built-in weights, 111b picks user weights.
// (RQ6) Five-bit ratio field sets overall oversampling and final data rate.
// (RQ7) User weights live behind address 13h as a 512-byte store.
// (RQ8) Every completed access to the store advances the byte pointer.
// (RQ9) Bytes go MSB first, tap 127 first, byte 512 is LSB of tap 0.
// (RQ10) Any other address during a sequence returns the pointer to the start.
// (RQ11) Clearing the serial error flag restarts the weight transfer at byte one.
// (RQ12) Host leaves at least 10 clocks between frames during weight access.
// (RQ13) Host synchronizes after loading weights so filtering restarts.
// (RQ14) Host pads unused end taps with zero weights.
// (RQ15) Built-in weights are linear phase with fixed group delay.
// (RQ16) Synchronization restarts the filter and clears its history.
// (RQ17) After sync, output is withheld until settled, plus 16 clocks overhead.
// (RQ18) Without sync nothing is suppressed; unsettled data passes through.
// (RQ19) With final stage and IIR off, half-band data goes straight out.
// (RQ20) All products summed at full precision, then rounded to output width.
`timescale 1ns/1ns
module final_decimator_coef_bank
    import decim_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_access,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic serial_error_clear,
    input wire logic [2:0] filter_source_select,
    input wire logic [4:0] decimation_ratio_select,
    input wire logic final_stage_bypass,
    input wire logic iir_bypass,
    input wire logic converter_sync,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [decim_pkg::SAMPLE_W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [decim_pkg::SAMPLE_W-1:0] out_data,
    output logic [4:0] active_ratio,
    output logic settling,
    output logic [decim_pkg::BANK_PTR_W-1:0] bank_pointer
);
    import decim_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] bank [BANK_BYTES];
    logic [SAMPLE_W-1:0] hist [TAPS];
    logic [TAP_IDX_W-1:0] wr_pos;
    logic [TAP_IDX_W-1:0] newest;
    logic [TAP_IDX_W:0] fill;
    logic phase;
    fir_state_t state;
    logic [TAP_IDX_W-1:0] tap;
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] product;
    logic [SAMPLE_W-1:0] result;
    logic [SAMPLE_W-1:0] tap_sample;
    logic [COEF_W-1:0] tap_coef;
    logic [COEF_W-1:0] user_coef;
    logic [BANK_PTR_W-1:0] coef_base;
    logic use_user;
    logic [6:0] settle_left;
    logic [4:0] overhead_left;
    logic first_pending;
    logic [SAMPLE_W-1:0] fifo_wr_data;
    logic fifo_wr_valid;
    logic fifo_wr_ready;
    logic pass_through;
    logic take_in;
    logic bank_hit;

    // ------------------------------------------------------------
    // Tap weight window
    // ------------------------------------------------------------
    assign bank_hit = reg_access && (reg_addr == TAP_WEIGHT_WINDOW_ADDR); // [RQ7]

    always_ff @(posedge clk) begin
        if (bank_hit && reg_write) begin
            bank[bank_pointer] <= reg_wdata; // [RQ9]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bank_pointer <= BANK_PTR_FIRST;
        end else if (serial_error_clear) begin
            bank_pointer <= BANK_PTR_FIRST; // [RQ11]
        end else if (reg_access && !bank_hit) begin
            bank_pointer <= BANK_PTR_FIRST; // [RQ10]
        end else if (bank_hit) begin
            if (bank_pointer == BANK_PTR_LAST) begin
                bank_pointer <= BANK_PTR_FIRST;
            end else begin
                bank_pointer <= bank_pointer + 1'b1; // [RQ8]
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else if (bank_hit && !reg_write) begin
            reg_rdata <= bank[bank_pointer]; // [RQ9]
        end
    end

    // ------------------------------------------------------------
    // Configuration latched at sync
    // ------------------------------------------------------------
    // Ratio takes effect only at sync, like the rest of the chain
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            active_ratio <= '0;
        end else if (converter_sync) begin
            active_ratio <= decimation_ratio_select; // [RQ6]
        end
    end

    // Weight source latched so a change applies only from the next sync
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            use_user <= 1'b0;
        end else if (converter_sync) begin
            use_user <= (filter_source_select == SRC_USER); // [RQ5]
        end
    end

    // ------------------------------------------------------------
    // Sample history
    // ------------------------------------------------------------
    assign pass_through = final_stage_bypass; // [RQ3]
    assign in_ready = pass_through ? fifo_wr_ready : (state == ST_IDLE);
    assign take_in = in_valid && in_ready && !converter_sync;

    always_ff @(posedge clk) begin
        if (take_in && !pass_through) begin
            hist[wr_pos] <= in_data;
        end
    end

    // Write index and newest entry of the circular history
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_pos <= '0;
            newest <= '0;
        end else if (take_in && !pass_through) begin
            newest <= wr_pos;
            wr_pos <= wr_pos + 1'b1;
        end
    end

    // Samples seen since sync; older entries read as zero so no stale history leaks in
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fill <= '0;
        end else if (converter_sync) begin
            fill <= '0; // [RQ16]
        end else if (take_in && !pass_through && fill != (TAP_IDX_W+1)'(TAPS)) begin
            fill <= fill + 1'b1;
        end
    end

    // Every second accepted sample starts a pass, which halves the rate
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase <= 1'b0;
        end else if (converter_sync) begin
            phase <= 1'b0;
        end else if (take_in && !pass_through) begin
            phase <= ~phase; // [RQ1]
        end
    end

    // ------------------------------------------------------------
    // Multiply-accumulate
    // ------------------------------------------------------------
    assign coef_base = {TOP_TAP - tap, 2'b00};
    assign tap_sample = ({1'b0, tap} < fill) ? hist[newest - tap] : '0; // [RQ16]

    // ------------------------------------------------------------
    // Coefficient byte lanes
    // ------------------------------------------------------------
    // Lane 0 is the most significant byte, the first one sent for each tap
    for (genvar lane = 0; lane < COEF_W / 8; lane++) begin : g_lane
        assign user_coef[COEF_W-1-8*lane -: 8] = bank[coef_base + BANK_PTR_W'(lane)]; // [RQ9]
    end

    always_comb begin
        if (use_user) begin
            tap_coef = user_coef; // [RQ9]
        end else begin
            tap_coef = BUILTIN_COEF; // [RQ15]
        end
    end

    assign product = ACC_W'($signed(tap_sample) * $signed(tap_coef)); // [RQ2]
    assign result = SAMPLE_W'((acc + $signed(ROUND_ADD)) >>> ROUND_POS); // [RQ20]

    // ------------------------------------------------------------
    // Accumulator and output word
    // ------------------------------------------------------------
    // Tap counter runs only while accumulating
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tap <= '0;
        end else if (state == ST_MAC) begin
            tap <= tap + 1'b1;
        end else begin
            tap <= '0;
        end
    end

    // Cleared while idle so every pass starts from zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc <= '0;
        end else if (converter_sync || state == ST_IDLE) begin
            acc <= '0; // [RQ16]
        end else if (state == ST_MAC) begin
            acc <= acc + product; // [RQ20]
        end
    end

    // Rounded word waits here until the FIFO takes it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fifo_wr_data <= '0;
        end else if (state == ST_ROUND) begin
            fifo_wr_data <= result; // [RQ20]
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
        end else if (converter_sync) begin
            state <= ST_IDLE; // [RQ16]
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (take_in && !pass_through && phase) begin
                        state <= ST_MAC; // [RQ1]
                    end
                end
                ST_MAC: begin
                    if (tap == TOP_TAP) begin
                        state <= ST_ROUND;
                    end
                end
                ST_ROUND: begin
                    if (settle_left != '0) begin
                        state <= ST_IDLE; // [RQ17]
                    end else if (first_pending) begin
                        state <= ST_HOLD; // [RQ4]
                    end else begin
                        state <= ST_PUSH; // [RQ18]
                    end
                end
                ST_HOLD: begin
                    if (overhead_left == '0) begin
                        state <= ST_PUSH;
                    end
                end
                ST_PUSH: begin
                    if (fifo_wr_ready) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Settling suppression
    // ------------------------------------------------------------
    // Conversions still to drop after sync
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            settle_left <= '0;
        end else if (converter_sync) begin
            if (filter_source_select == SRC_USER) begin
                settle_left <= SETTLE_USER; // [RQ4]
            end else begin
                settle_left <= SETTLE_BUILTIN; // [RQ17]
            end
        end else if (state == ST_ROUND && settle_left != '0) begin
            settle_left <= settle_left - 1'b1;
        end
    end

    // High from sync until the first kept word is released
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            first_pending <= 1'b0;
        end else if (converter_sync) begin
            first_pending <= 1'b1;
        end else if (state == ST_HOLD && overhead_left == '0) begin
            first_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            overhead_left <= OVERHEAD_CLKS;
        end else if (converter_sync) begin
            overhead_left <= OVERHEAD_CLKS;
        end else if (state == ST_HOLD && overhead_left != '0) begin
            overhead_left <= overhead_left - 1'b1; // [RQ17]
        end
    end

    assign settling = first_pending;

    // ------------------------------------------------------------
    // Output path
    // ------------------------------------------------------------
    // Bypass sends half-band samples straight on, no decimation
    assign fifo_wr_valid = pass_through ? (in_valid && !converter_sync) : (state == ST_PUSH); // [RQ19]

    sample_fifo #(
        .WIDTH(SAMPLE_W),
        .DEPTH(FIFO_DEPTH),
        .PTR_W(FIFO_PTR_W)
    ) u_out_fifo (
        .clk(clk),
        .resetn(resetn),
        .wr_valid(fifo_wr_valid),
        .wr_ready(fifo_wr_ready),
        .wr_data(pass_through ? in_data : fifo_wr_data),
        .rd_valid(out_valid),
        .rd_ready(out_ready),
        .rd_data(out_data)
    );
endmodule

// >>> logic/sample_fifo.sv
// Synchronous valid/ready FIFO for output samples
`timescale 1ns/1ns
module sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16,
    parameter int PTR_W = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
    logic do_wr;
    logic do_rd;

    assign wr_ready = (count != (PTR_W+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign rd_valid = (count != '0);
    assign do_wr = wr_valid && wr_ready;
    assign do_rd = rd_valid && rd_ready;
    assign rd_data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// >>> test/decim_checker_asserts.sv
// Port assertions for the final decimation stage
`timescale 1ns/1ns
module decim_checker
    import decim_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_access,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic serial_error_clear,
    input wire logic [4:0] decimation_ratio_select,
    input wire logic final_stage_bypass,
    input wire logic converter_sync,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic [decim_pkg::SAMPLE_W-1:0] in_data,
    input wire logic out_valid,
    input wire logic [decim_pkg::SAMPLE_W-1:0] out_data,
    input wire logic [4:0] active_ratio,
    input wire logic settling,
    input wire logic [decim_pkg::BANK_PTR_W-1:0] bank_pointer
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence window_hit;
        reg_access && reg_addr == TAP_WEIGHT_WINDOW_ADDR && !serial_error_clear;
    endsequence
    a_ptr_advance: assert property (window_hit ##0 bank_pointer != BANK_PTR_LAST
        |=> bank_pointer == $past(bank_pointer) + 9'h001) else $error("pointer did not advance");
    a_ptr_wrap: assert property (window_hit ##0 bank_pointer == BANK_PTR_LAST
        |=> bank_pointer == BANK_PTR_FIRST) else $error("pointer did not wrap");
    a_other_addr: assert property (reg_access && reg_addr != TAP_WEIGHT_WINDOW_ADDR
        |=> bank_pointer == BANK_PTR_FIRST) else $error("pointer kept after other address");
    a_clear_restart: assert property (serial_error_clear |=> bank_pointer == BANK_PTR_FIRST)
        else $error("pointer kept after error clear");
    a_ratio_latch: assert property (converter_sync |=> active_ratio == $past(decimation_ratio_select))
        else $error("ratio not latched on sync");
    a_sync_settle: assert property (converter_sync && !final_stage_bypass |=> settling)
        else $error("no settling after sync");
    a_bypass_pass: assert property (final_stage_bypass && in_valid && in_ready && !converter_sync
        && !out_valid |=> out_valid && out_data == $past(in_data)) else $error("bypass sample lost");
    a_rdata_hold: assert property (!(reg_access && !reg_write && reg_addr == TAP_WEIGHT_WINDOW_ADDR)
        |=> $stable(reg_rdata)) else $error("read byte changed without read");
endmodule

bind final_decimator_coef_bank decim_checker u_chk (.*);

// >>> test/host_model.sv
// Host controller model for the tap weight window and sync strobes
`timescale 1ns/1ns
module host_model
    import decim_pkg::*;
(
    input wire logic clk,
    output logic reg_access,
    output logic reg_write,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic serial_error_clear,
    output logic converter_sync
);
    logic [COEF_W-1:0] taps [TAPS] = '{default: 32'h0000_0000};
    initial begin
        reg_access = 1'b0;
        reg_write = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        serial_error_clear = 1'b0;
        converter_sync = 1'b0;
    end
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        reg_access = 1'b1;
        reg_write = wr;
        reg_addr = addr;
        reg_wdata = data;
        @(negedge clk);
        reg_access = 1'b0;
        reg_wdata = ~data;
        repeat (MIN_FRAME_GAP_CLKS) @(negedge clk);
    endtask
    // Error-flag clear when is_sync is low, converter sync otherwise
    task automatic strobe(input logic is_sync);
        @(negedge clk);
        serial_error_clear = !is_sync;
        converter_sync = is_sync;
        @(negedge clk);
        serial_error_clear = 1'b0;
        converter_sync = 1'b0;
    endtask
    task automatic load_taps();
        for (int k = TAPS - 1; k >= 0; k--)
            for (int b = 3; b >= 0; b--)
                access(1'b1, TAP_WEIGHT_WINDOW_ADDR, taps[k][b * 8 +: 8]);
        strobe(1'b1);
    endtask
endmodule

// >>> test/tb_final_decimator_coef_bank.sv
// Self-checking bench for the final decimation stage
`timescale 1ns/1ns
module tb_final_decimator_coef_bank;
    import decim_pkg::*;
    logic clk, resetn, reg_access, reg_write, serial_error_clear, final_stage_bypass, iir_bypass;
    logic converter_sync, in_valid, in_ready, out_valid, out_ready, settling;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] filter_source_select;
    logic [4:0] decimation_ratio_select, active_ratio;
    logic [SAMPLE_W-1:0] in_data, out_data, n_in, feed_base, feed_step;
    logic [BANK_PTR_W-1:0] bank_pointer;
    int n_errors, total_checks;
    final_decimator_coef_bank uut (.*);
    host_model host (.*);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
        if (in_valid && in_ready && !converter_sync)
            n_in <= n_in + 24'h00_0001;
    always @(negedge clk)
        in_data <= feed_base + feed_step * n_in;
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wait_out();
        int i;
        for (i = 0; i < 20000 && out_valid !== 1'b1; i++)
            @(negedge clk);
        if (i == 20000) begin
            check("out_valid timeout", 1, 0);
            print_verdict();
        end
    endtask
    task automatic test_bypass();
        int i;
        final_stage_bypass = 1'b1;
        iir_bypass = 1'b1;
        feed_base = 24'h00_1000;
        feed_step = 24'h00_0001;
        n_in = 24'h00_0000;
        @(negedge clk);
        in_valid = 1'b1;
        for (i = 0; i < 100 && in_ready !== 1'b0; i++)
            @(negedge clk);
        in_valid = 1'b0;
        check("fifo fill", FIFO_DEPTH, n_in);
        out_ready = 1'b1;
        for (i = 0; i < FIFO_DEPTH; i++) begin
            wait_out();
            check("bypass data", 24'h00_1000 + i, out_data);
            @(negedge clk);
        end
        check("fifo empty", 0, out_valid);
        $display("test_bypass done");
    endtask
    task automatic test_window();
        repeat (3) host.access(1'b1, TAP_WEIGHT_WINDOW_ADDR, 8'hA5);
        check("pointer step", 3, bank_pointer);
        host.access(1'b0, 8'h12, 8'h00);
        check("pointer other", 0, bank_pointer);
        repeat (2) host.access(1'b1, TAP_WEIGHT_WINDOW_ADDR, 8'h5A);
        host.strobe(1'b0);
        check("pointer clear", 0, bank_pointer);
        $display("test_window done");
    endtask
    task automatic test_user();
        logic [31:0] exp_w;
        host.taps[0] = 32'h4000_0000;
        host.taps[1] = COEF_MIN;
        host.taps[127] = 32'h0000_00C3;
        filter_source_select = SRC_USER;
        decimation_ratio_select = 5'h0A;
        final_stage_bypass = 1'b0;
        host.load_taps();
        check("pointer wrap", 0, bank_pointer);
        check("ratio latch", 5'h0A, active_ratio);
        check("settling", 1, settling);
        for (int k = 0; k < BANK_BYTES; k++) begin
            host.access(1'b0, TAP_WEIGHT_WINDOW_ADDR, 8'h00);
            exp_w = host.taps[TAPS - 1 - k / 4];
            check("readback", exp_w[(3 - k % 4) * 8 +: 8], reg_rdata);
        end
        feed_base = 24'h00_0100;
        feed_step = 24'h00_0000;
        n_in = 24'h00_0000;
        @(negedge clk);
        in_valid = 1'b1;
        wait_out();
        check("user latency", 1, n_in == 24'h00_0098 || n_in == 24'h00_0099);
        check("user output", 24'hFF_FF80, out_data);
        check("settled", 0, settling);
        $display("test_user done");
    endtask
    task automatic test_builtin();
        filter_source_select = SRC_BUILTIN;
        decimation_ratio_select = 5'h15;
        feed_base = 24'h00_0300;
        host.strobe(1'b1);
        n_in = 24'h00_0000;
        repeat (4) @(negedge clk);
        wait_out();
        check("builtin latency", 1, n_in == 24'h00_008A || n_in == 24'h00_008B);
        check("builtin output", 24'h00_0300, out_data);
        check("ratio latch", 5'h15, active_ratio);
        @(negedge clk);
        wait_out();
        check("next output", 24'h00_0300, out_data);
        in_valid = 1'b0;
        $display("test_builtin done");
    endtask
    initial begin
        resetn = 1'b0;
        in_valid = 1'b0;
        out_ready = 1'b0;
        final_stage_bypass = 1'b0;
        iir_bypass = 1'b0;
        filter_source_select = SRC_BUILTIN;
        decimation_ratio_select = 5'h00;
        feed_base = 24'h00_0000;
        feed_step = 24'h00_0000;
        n_in = 24'h00_0000;
        n_errors = 0;
        total_checks = 0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        check("reset", {1'b1, 24'h00_0000}, {in_ready, out_valid, settling, active_ratio, bank_pointer, reg_rdata});
        resetn = 1'b1;
        test_bypass();
        test_window();
        test_user();
        test_builtin();
        print_verdict();
    end
endmodule
